//--- pci_term_map.svh
// Register offsets, field positions, reset values and timing counts of the PCI target and master logic.
`ifndef PCI_TERM_MAP_SVH
`define PCI_TERM_MAP_SVH

`define ADR_CTRL        4'h0
`define ADR_STAT        4'h4
`define ADR_MCMD        4'h8

`define CTRL_PRE        0
`define CTRL_MEB        1
`define CTRL_WIE        2
`define CTRL_ARB        3
`define CTRL_WIDE       4
`define CTRL_W          5
`define CTRL_RESET      5'h00
`define CTRL_WMASK      5'h1b

`define STAT_DPE        0
`define STAT_STA        1
`define STAT_ERR        2
`define STAT_CMD        3
`define STAT_FLAGS      4
`define STAT_MBUSY      4
`define STAT_DRLAT      5

`define DR_MIN_BYTES    8'h08
`define DR_AGE_DEFAULT  32768
`define DR_AGE_MAX      1048576
`define DR_AGE_W        20

`define CMD_IACK        4'h0
`define CMD_SPECIAL     4'h1
`define CMD_IO_RD       4'h2
`define CMD_IO_WR       4'h3
`define CMD_MEM_RD      4'h6
`define CMD_MEM_WR      4'h7
`define CMD_CFG_RD      4'ha
`define CMD_CFG_WR      4'hb
`define CMD_MEM_RDM     4'hc
`define CMD_DUAL        4'hd
`define CMD_MEM_RDL     4'he
`define CMD_MWI         4'hf

`endif

//--- pci_term_pkg.sv
// Types shared by the PCI target termination and master request logic.
package pci_term_pkg;

  typedef enum logic [1:0] {
    T_IDLE = 2'b00,
    T_WAIT = 2'b01,
    T_DATA = 2'b11,
    T_TURN = 2'b10
  } tstate_t;

  typedef enum logic [1:0] {
    M_IDLE = 2'b00,
    M_REQ  = 2'b01,
    M_ADDR = 2'b11,
    M_DONE = 2'b10
  } mstate_t;

  typedef struct packed {
    logic        pci_clk;
    logic        frame_n;
    logic        irdy_n;
    logic        gnt_n;
    logic        other_req_n;
    logic        par;
    logic        par64;
    logic [7:0]  cbe_n;
    logic [63:0] ad;
  } pci_in_t;

  typedef struct packed {
    logic        devsel_n;
    logic        trdy_n;
    logic        stop_n;
    logic        tctl_oe;
    logic        perr_n;
    logic        perr_oe;
    logic        par;
    logic        par64;
    logic        par_oe;
    logic [63:0] ad;
    logic        ad_oe;
    logic        frame_n;
    logic        frame_oe;
    logic [3:0]  cbe_n;
    logic        cbe_oe;
    logic        req_n;
    logic        arb_gnt_n;
  } pci_out_t;

  typedef struct packed {
    logic       hit;
    logic       is_read;
    logic       reg_access;
    logic       nonlinear;
    logic       wbuf_full;
    logic       rbuf_empty;
    logic       at_4k;
    logic       pb_bus_err;
    logic       retry_limit;
    logic       alt_abort;
    logic [7:0] rd_bytes;
  } target_in_t;

  typedef struct packed {
    logic err_log;
    logic dr_fetch;
    logic dr_free;
    logic master_done;
  } event_out_t;

endpackage : pci_term_pkg

//--- pci_term_ctrl.sv
// PCI target terminations, parity handling, master request and command issue with a Wishbone register slave.
//
// Added by the designer: the register offsets and register access over Wishbone.
`include "pci_term_map.svh"

module pci_term_ctrl
  import pci_term_pkg::*;
#(
  parameter int DR_AGE_CLOCKS = `DR_AGE_DEFAULT
) (
  input  wire logic        clk,       // System clock, 40 MHz.
  input  wire logic        rst,       // Asynchronous reset, active high.
  input  wire logic        wb_cyc,    // Wishbone cycle.
  input  wire logic        wb_stb,    // Wishbone strobe.
  input  wire logic        wb_we,     // Wishbone write enable.
  input  wire logic [3:0]  wb_adr,    // Wishbone byte address.
  input  wire logic [3:0]  wb_sel,    // Wishbone byte selects.
  input  wire logic [31:0] wb_dat_i,  // Wishbone write data.
  output logic      [31:0] wb_dat_o,  // Wishbone read data.
  output logic             wb_ack,    // Wishbone acknowledge.
  input  wire pci_in_t     pci_in,    // PCI pins and link clock, asynchronous.
  output pci_out_t         pci_out,   // PCI pin drives and enables.
  input  wire target_in_t  tgt,       // Decode and buffer state from the bridge core.
  input  wire logic [63:0] rd_data,   // Read data for the current target data phase.
  input  wire logic        src_req,   // Master transaction request from the core.
  input  wire logic [3:0]  src_cmd,   // Command for src_req.
  output event_out_t       evt        // One-cycle event pulses to the core.
);

  if (DR_AGE_CLOCKS < 2 || DR_AGE_CLOCKS > `DR_AGE_MAX) begin : g_chk
    $error("DR_AGE_CLOCKS out of range");
  end

  // Register file and Wishbone slave.
  logic [`CTRL_W-1:0]     ctrl;
  logic [`STAT_FLAGS-1:0] flags;
  logic [`STAT_FLAGS-1:0] flag_set;
  logic [3:0]             pend_cmd;
  logic                   m_pend;
  logic                   dr_valid;
  tstate_t                tstate;
  tstate_t                next_tstate;
  mstate_t                mstate;
  mstate_t                next_mstate;

  wire wb_req   = wb_cyc & wb_stb & ~wb_ack;
  wire wr_ctrl  = wb_req & wb_we & wb_sel[0] & (wb_adr == `ADR_CTRL);
  wire wr_stat  = wb_req & wb_we & wb_sel[0] & (wb_adr == `ADR_STAT);
  wire wr_mcmd  = wb_req & wb_we & wb_sel[0] & (wb_adr == `ADR_MCMD);
  wire pre      = ctrl[`CTRL_PRE];
  wire meb      = ctrl[`CTRL_MEB];
  wire arb_en   = ctrl[`CTRL_ARB];
  wire wide     = ctrl[`CTRL_WIDE];
  wire m_busy   = (mstate != M_IDLE);
  wire [31:0] stat_word = {26'h0, dr_valid, m_busy, flags};
  wire [31:0] rd_word   = (wb_adr == `ADR_CTRL) ? {27'h0, ctrl} :
                          (wb_adr == `ADR_STAT) ? stat_word :
                          (wb_adr == `ADR_MCMD) ? {28'h0, pend_cmd} : 32'h0;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wb_ack   <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack   <= wb_req;
      wb_dat_o <= (wb_req & ~wb_we) ? rd_word : 32'h0;
    end
  end

  // The write-invalidate enable stays zero since that command is never issued.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl <= `CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl <= wb_dat_i[`CTRL_W-1:0] & `CTRL_WMASK;
    end
  end

  // Sticky flags clear on a written one; a set in the same cycle wins.
  wire [`STAT_FLAGS-1:0] flag_clr = wr_stat ? wb_dat_i[`STAT_FLAGS-1:0] : {`STAT_FLAGS{1'b0}};
  for (genvar i = 0; i < `STAT_FLAGS; i++) begin : g_flag
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        flags[i] <= 1'b0;
      end else begin
        flags[i] <= flag_set[i] | (flags[i] & ~flag_clr[i]);
      end
    end
  end

  // Pin synchroniser; the link clock edge is found on the second stage.
  pci_in_t pin_meta;
  pci_in_t ps;
  logic    pclk_d;
  logic    frame_prev;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_meta <= '1;
      ps       <= '1;
      pclk_d   <= 1'b1;
    end else begin
      pin_meta <= pci_in;
      ps       <= pin_meta;
      pclk_d   <= ps.pci_clk;
    end
  end
  wire pedge = ps.pci_clk & ~pclk_d;

  // Target decisions.
  logic t_read;
  logic devsel_n;
  logic trdy_n;
  logic stop_n;
  logic tctl_oe;
  wire m_active    = (mstate == M_ADDR) | (mstate == M_DONE);
  wire t_claim     = pedge & (tstate == T_IDLE) & ~ps.frame_n & frame_prev & tgt.hit & ~m_active;
  wire fatal       = tgt.pb_bus_err | tgt.retry_limit | (t_read & tgt.alt_abort);
  wire need_retry  = t_read & (tgt.rd_bytes < `DR_MIN_BYTES);
  wire buf_stall   = t_read ? tgt.rbuf_empty : tgt.wbuf_full;
  wire disc        = buf_stall | tgt.at_4k | tgt.reg_access | tgt.nonlinear;
  wire decide      = pedge & (tstate == T_WAIT);
  wire abort_evt   = decide & fatal;
  wire retry_evt   = decide & ~fatal & need_retry;
  wire xfer        = pedge & (tstate == T_DATA) & ~ps.irdy_n & ~trdy_n;
  wire t_end       = xfer & ps.frame_n;

  always_comb begin
    next_tstate = tstate;
    case (tstate)
      T_IDLE:  next_tstate = t_claim ? T_WAIT : T_IDLE;
      T_WAIT:  next_tstate = !decide ? T_WAIT : ((fatal | need_retry) ? T_TURN : T_DATA);
      T_DATA:  next_tstate = t_end ? T_TURN : T_DATA;
      T_TURN:  next_tstate = (pedge & ps.frame_n) ? T_IDLE : T_TURN;
      default: next_tstate = T_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tstate     <= T_IDLE;
      frame_prev <= 1'b1;
      t_read     <= 1'b0;
    end else begin
      tstate <= next_tstate;
      if (pedge) begin
        frame_prev <= ps.frame_n;
      end
      if (t_claim) begin
        t_read <= tgt.is_read;
      end
    end
  end

  // Target control pins: disconnect keeps ready with stop, retry keeps ready off, abort drops select.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      devsel_n <= 1'b1;
      trdy_n   <= 1'b1;
      stop_n   <= 1'b1;
      tctl_oe  <= 1'b0;
    end else if (pedge) begin
      case (tstate)
        T_IDLE: begin
          tctl_oe <= t_claim;
        end
        T_WAIT: begin
          devsel_n <= fatal;
          trdy_n   <= fatal | need_retry;
          stop_n   <= ~(fatal | need_retry | disc);
        end
        T_DATA: begin
          devsel_n <= t_end;
          trdy_n   <= t_end;
          stop_n   <= t_end | ~disc;
        end
        T_TURN: begin
          devsel_n <= 1'b1;
          trdy_n   <= 1'b1;
          stop_n   <= 1'b1;
        end
        default: begin
          tctl_oe <= 1'b0;
        end
      endcase
    end
  end

  // Parity: lower lanes always, upper lanes in wide mode; a check runs one link clock after its phase.
  logic chk_pend;
  logic chk_data;
  logic exp_lo;
  logic exp_hi;
  wire par_lo  = ^{ps.ad[31:0], ps.cbe_n[3:0]};
  wire par_hi  = ^{ps.ad[63:32], ps.cbe_n[7:4]};
  wire chk_now = pedge & chk_pend;
  wire par_bad = chk_now & ((exp_lo ^ ps.par) | (wide & (exp_hi ^ ps.par64)));
  wire wr_xfer = xfer & ~t_read;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      chk_pend <= 1'b0;
      chk_data <= 1'b0;
      exp_lo   <= 1'b0;
      exp_hi   <= 1'b0;
    end else if (pedge) begin
      chk_pend <= t_claim | wr_xfer;
      chk_data <= wr_xfer;
      exp_lo   <= par_lo;
      exp_hi   <= par_hi;
    end
  end

  // Parity error pin: low for one link clock, then driven high one more before release.
  logic perr_n;
  logic perr_oe;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      perr_n  <= 1'b1;
      perr_oe <= 1'b0;
    end else if (pedge) begin
      if (par_bad & chk_data & pre) begin
        perr_n  <= 1'b0;
        perr_oe <= 1'b1;
      end else begin
        perr_n  <= 1'b1;
        perr_oe <= ~perr_n;
      end
    end
  end

  // Read data and its parity, which trails the data by one link clock.
  logic [63:0] ad_q;
  logic        ad_oe;
  logic        par_q;
  logic        par64_q;
  logic        par_oe;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ad_q    <= 64'h0;
      ad_oe   <= 1'b0;
      par_q   <= 1'b0;
      par64_q <= 1'b0;
      par_oe  <= 1'b0;
    end else if (pedge) begin
      ad_q    <= rd_data;
      ad_oe   <= t_read & (next_tstate == T_DATA);
      par_q   <= ^{ad_q[31:0], ps.cbe_n[3:0]};
      par64_q <= wide & ^{ad_q[63:32], ps.cbe_n[7:4]};
      par_oe  <= ad_oe;
    end
  end

  // Delayed read latch; a master that never returns must not hold the buffer forever.
  logic [`DR_AGE_W-1:0] dr_age;
  wire dr_expire = pedge & dr_valid & (dr_age == `DR_AGE_W'(DR_AGE_CLOCKS - 1));
  wire dr_take   = retry_evt & ~dr_valid;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dr_valid <= 1'b0;
      dr_age   <= '0;
    end else if (dr_take) begin
      dr_valid <= 1'b1;
      dr_age   <= '0;
    end else if (dr_expire | (t_end & t_read)) begin
      dr_valid <= 1'b0;
    end else if (pedge & dr_valid) begin
      dr_age <= dr_age + `DR_AGE_W'(1);
    end
  end

  // Master: command latch, arbitration and address phase.
  function automatic logic cmd_ok(input logic [3:0] c);
    case (c)
      `CMD_IACK, `CMD_IO_RD, `CMD_IO_WR, `CMD_MEM_RD, `CMD_MEM_WR,
      `CMD_CFG_RD, `CMD_CFG_WR, `CMD_MEM_RDM, `CMD_MEM_RDL: cmd_ok = 1'b1;
      default: cmd_ok = 1'b0;
    endcase
  endfunction : cmd_ok

  wire       new_req  = wr_mcmd | src_req;
  wire [3:0] new_cmd  = wr_mcmd ? wb_dat_i[3:0] : src_cmd;
  wire       cmd_bad  = new_req & ~m_pend & ~cmd_ok(new_cmd);
  wire       own_req  = (mstate == M_REQ);
  wire       other_rq = ~ps.other_req_n;
  logic      own_gnt;
  wire       granted  = arb_en ? own_gnt : ~ps.gnt_n;
  wire       bus_idle = ps.frame_n & ps.irdy_n;
  wire       m_start  = pedge & own_req & granted & bus_idle & meb & (tstate == T_IDLE);

  always_comb begin
    next_mstate = mstate;
    case (mstate)
      M_IDLE:  next_mstate = (m_pend & meb) ? M_REQ : M_IDLE;
      M_REQ:   next_mstate = !meb ? M_IDLE : (m_start ? M_ADDR : M_REQ);
      M_ADDR:  next_mstate = pedge ? M_DONE : M_ADDR;
      M_DONE:  next_mstate = pedge ? M_IDLE : M_DONE;
      default: next_mstate = M_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mstate   <= M_IDLE;
      m_pend   <= 1'b0;
      pend_cmd <= `CMD_MEM_RD;
    end else begin
      mstate <= next_mstate;
      if (new_req & ~m_pend & cmd_ok(new_cmd)) begin
        m_pend   <= 1'b1;
        pend_cmd <= new_cmd;
      end else if (pedge & (mstate == M_DONE)) begin
        m_pend <= 1'b0;
      end
    end
  end

  // Master pins; the internal arbiter parks on this master when nobody asks.
  logic       frame_n;
  logic       frame_oe;
  logic [3:0] cbe_q;
  logic       cbe_oe;
  logic       req_n;
  logic       arb_gnt_n;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      frame_n   <= 1'b1;
      frame_oe  <= 1'b0;
      cbe_q     <= 4'hf;
      cbe_oe    <= 1'b0;
      req_n     <= 1'b1;
      own_gnt   <= 1'b0;
      arb_gnt_n <= 1'b1;
    end else begin
      req_n <= ~(own_req & ~arb_en);
      if (pedge) begin
        own_gnt   <= arb_en & (own_req | ~other_rq);
        arb_gnt_n <= ~(arb_en & other_rq & ~own_req);
        frame_n   <= ~m_start;
        frame_oe  <= m_start | (mstate == M_ADDR);
        cbe_q     <= m_start ? pend_cmd : 4'hf;
        cbe_oe    <= m_start;
      end
    end
  end

  // Events and flag sources.
  assign flag_set = {cmd_bad, par_bad | abort_evt, abort_evt, par_bad};
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      evt <= '0;
    end else begin
      evt.err_log     <= par_bad | abort_evt;
      evt.dr_fetch    <= dr_take;
      evt.dr_free     <= dr_expire;
      evt.master_done <= pedge & (mstate == M_DONE);
    end
  end

  assign pci_out = '{devsel_n: devsel_n, trdy_n: trdy_n, stop_n: stop_n, tctl_oe: tctl_oe,
                     perr_n: perr_n, perr_oe: perr_oe, par: par_q, par64: par64_q, par_oe: par_oe,
                     ad: ad_q, ad_oe: ad_oe, frame_n: frame_n, frame_oe: frame_oe, cbe_n: cbe_q,
                     cbe_oe: cbe_oe, req_n: req_n, arb_gnt_n: arb_gnt_n};

  // Checks on the driven behaviour.
  a_retry_shape: assert property (@(posedge clk) disable iff (rst)
    retry_evt |=> !stop_n && !devsel_n && trdy_n) else $error("retry shape wrong");
  a_abort_shape: assert property (@(posedge clk) disable iff (rst)
    abort_evt |=> !stop_n && devsel_n && trdy_n && flags[`STAT_STA]) else $error("abort shape wrong");
  a_disc_ready: assert property (@(posedge clk) disable iff (rst)
    (tstate == T_DATA) && !stop_n && tctl_oe && !devsel_n |-> !trdy_n) else $error("disconnect lacks ready");
  a_parity_flag: assert property (@(posedge clk) disable iff (rst)
    par_bad |=> flags[`STAT_DPE] && evt.err_log) else $error("parity flag not set");
  a_perr_gated: assert property (@(posedge clk) disable iff (rst)
    $fell(perr_n) |-> $past(pre) && $past(chk_data)) else $error("parity pin without enable");
  a_frame_start: assert property (@(posedge clk) disable iff (rst)
    $fell(frame_n) |-> $past(meb) && $past(granted) && $past(own_req)) else $error("frame without grant");
  a_cmd_legal: assert property (@(posedge clk) disable iff (rst)
    cbe_oe |-> cmd_ok(cbe_q)) else $error("illegal command issued");
  a_no_dual_role: assert property (@(posedge clk) disable iff (rst)
    m_active |-> tstate == T_IDLE) else $error("master and target together");
  a_req_route: assert property (@(posedge clk) disable iff (rst)
    own_req && arb_en ##1 own_req && arb_en |-> req_n) else $error("pin request with arbiter");
  a_dr_free: assert property (@(posedge clk) disable iff (rst)
    dr_expire |=> !dr_valid && evt.dr_free) else $error("delayed read not freed");
  a_wie_zero: assert property (@(posedge clk) disable iff (rst)
    !ctrl[`CTRL_WIE]) else $error("write-invalidate enable set");

  c_retry: cover property (@(posedge clk) disable iff (rst) retry_evt);
  c_abort: cover property (@(posedge clk) disable iff (rst) abort_evt);
  c_master: cover property (@(posedge clk) disable iff (rst) m_start ##[1:20] evt.master_done);

endmodule : pci_term_ctrl

//--- pci_far_model.sv
// Far-side PCI agent: link clock, one-phase initiator and a grant that follows the request.
module pci_far_model
  import pci_term_pkg::*;
(
  input  wire logic     clk,     // System clock.
  input  wire logic     rst,     // Reset, active high.
  input  wire pci_out_t pci_out, // Bridge pin drives.
  output pci_in_t       pci_in   // Pins this agent drives.
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] ph;
  initial begin
    ph = 3'h0;
    pci_in = '1;
    // Upper lanes idle at all ones, so even parity over them is zero.
    pci_in.par64 = 1'b0;
  end
  // The link clock is eight system clocks long and changes only with the system clock edge.
  always @(posedge clk) begin
    ph <= ph + 3'h1;
    pci_in.pci_clk <= (ph == 3'h7) || (ph < 3'h3);
    if (ph == 3'h6) begin
      pci_in.gnt_n <= pci_out.req_n | rst;
    end
  end
  // Inputs change one system clock before the link edge so they reach the bridge settled.
  task automatic step();
    @(posedge clk);
    while (ph != 3'h6) begin
      @(posedge clk);
    end
  endtask : step
  task automatic txn(input logic [3:0] cmd, input logic [31:0] data, input logic bad,
                     output pci_out_t dec, output pci_out_t late);
    step();
    pci_in.frame_n <= 1'b0;
    pci_in.ad[31:0] <= 32'h0000_1000;
    pci_in.cbe_n[3:0] <= cmd;
    step();
    pci_in.par <= ^{32'h0000_1000, cmd};
    pci_in.frame_n <= 1'b1;
    pci_in.irdy_n <= 1'b0;
    pci_in.cbe_n[3:0] <= 4'h0;
    pci_in.ad[31:0] <= cmd[0] ? data : 32'hffff_efff;
    step();
    dec = pci_out;
    step();
    late = pci_out;
    pci_in.irdy_n <= 1'b1;
    pci_in.par <= ^{data, 4'h0} ^ bad;
    pci_in.ad[31:0] <= ~data;
    repeat (4) step();
  endtask : txn
endmodule : pci_far_model

//--- pci_target_term_and_master_request_bench.sv
// Self-checking bench for the PCI target termination and master request block.
`include "pci_term_map.svh"
module pci_target_term_and_master_request_bench
  import pci_term_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst, wb_cyc, wb_stb, wb_we, wb_ack, src_req, ext_arb;
  logic [3:0]  wb_adr, wb_sel, src_cmd, last_cmd;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic [63:0] rd_data;
  pci_in_t     pci_in;
  pci_out_t    pci_out, dec, late;
  target_in_t  tgt;
  event_out_t  evt;
  int          miscompares, tests_run, n_log, n_fetch, n_free, n_done, n_perr, n_frame, n_bad, n_pin;
  bit          fr, fr_prev;

  pci_term_ctrl #(.DR_AGE_CLOCKS(16)) pci_term_ctrl_inst (.clk(clk), .rst(rst), .wb_cyc(wb_cyc),
    .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack(wb_ack), .pci_in(pci_in), .pci_out(pci_out), .tgt(tgt),
    .rd_data(rd_data), .src_req(src_req), .src_cmd(src_cmd), .evt(evt));
  pci_far_model pci_far_model_inst (.clk(clk), .rst(rst), .pci_out(pci_out), .pci_in(pci_in));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    fr = (pci_out.frame_oe === 1'b1) && (pci_out.frame_n === 1'b0);
    if (fr && !fr_prev) begin
      n_frame++;
      last_cmd = pci_out.cbe_n;
      if (ext_arb && pci_in.gnt_n !== 1'b0) n_bad++;
    end
    fr_prev = fr;
    if (pci_out.frame_oe === 1'b1 && pci_out.tctl_oe === 1'b1) n_bad++;
    if (!ext_arb && pci_out.req_n === 1'b0) n_pin++;
    if (pci_out.perr_oe === 1'b1 && pci_out.perr_n === 1'b0) n_perr++;
    if (evt.err_log === 1'b1) n_log++;
    if (evt.dr_fetch === 1'b1) n_fetch++;
    if (evt.dr_free === 1'b1) n_free++;
    if (evt.master_done === 1'b1) n_done++;
  end

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : summarize
  task automatic check(input logic [31:0] seen, input logic [31:0] want, input string what);
    tests_run++;
    if (seen !== want) begin
      miscompares++;
      $display("MISMATCH at %0t: %s seen %h want %h", $time, what, seen, want);
    end
  endtask : check
  task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] dat, output logic [31:0] rd);
    @(posedge clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= adr;
    wb_dat_i <= dat;
    wb_sel <= 4'hf;
    @(posedge clk);
    while (wb_ack !== 1'b1) @(posedge clk);
    rd = wb_dat_o;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask : wb
  task automatic wr(input logic [3:0] adr, input logic [31:0] dat);
    logic [31:0] d;
    wb(1'b1, adr, dat, d);
  endtask : wr
  task automatic rd_chk(input logic [3:0] adr, input logic [31:0] mask, input logic [31:0] want, input string what);
    logic [31:0] d;
    wb(1'b0, adr, 32'h0, d);
    check(d & mask, want, what);
  endtask : rd_chk
  task automatic pulse(input logic [3:0] c);
    @(posedge clk);
    src_req <= 1'b1;
    src_cmd <= c;
    @(posedge clk);
    src_req <= 1'b0;
  endtask : pulse
  task automatic wait_done(input int n0);
    for (int k = 0; k < 400 && n_done == n0; k++) @(posedge clk);
    check(32'(n_done - n0), 32'h1, "master done");
  endtask : wait_done
  function automatic target_in_t mk(input logic rd, input logic [7:0] n, input logic [6:0] f);
    target_in_t t;
    t = '0;
    t.hit = 1'b1;
    t.is_read = rd;
    t.rd_bytes = n;
    {t.reg_access, t.nonlinear, t.rbuf_empty, t.at_4k, t.pb_bus_err, t.retry_limit, t.alt_abort} = f;
    return t;
  endfunction : mk
  function automatic logic [31:0] trm(input pci_out_t o);
    return {29'h0, o.devsel_n, o.trdy_n, o.stop_n};
  endfunction : trm

  task automatic t_regs();
    rd_chk(`ADR_CTRL, 32'hffffffff, 32'h0, "ctrl reset");
    rd_chk(`ADR_STAT, 32'hffffffff, 32'h0, "stat reset");
    rd_chk(`ADR_MCMD, 32'hf, 32'h6, "mcmd reset");
    wr(`ADR_CTRL, 32'h1f);
    rd_chk(`ADR_CTRL, 32'hffffffff, 32'h1b, "write invalidate enable");
    wr(4'hc, 32'hffffffff);
    rd_chk(4'hc, 32'hffffffff, 32'h0, "unmapped");
    wr(`ADR_CTRL, 32'h0);
    $display("register test done");
  endtask : t_regs
  task automatic t_retry();
    @(posedge clk);
    tgt <= mk(1'b1, 8'h07, 7'h00);
    pci_far_model_inst.txn(`CMD_MEM_RD, 32'h0, 1'b0, dec, late);
    check(trm(dec), 32'h2, "retry pins");
    check(trm(late), 32'h7, "released after retry");
    check(32'(n_fetch), 32'h1, "read latched");
    rd_chk(`ADR_STAT, 32'h20, 32'h20, "latch held");
    repeat (8 * 7) @(posedge clk);
    check(32'(n_free), 32'h0, "latch kept");
    repeat (8 * 7) @(posedge clk);
    check(32'(n_free), 32'h1, "latch aged out");
    rd_chk(`ADR_STAT, 32'h20, 32'h0, "latch freed");
    $display("retry test done");
  endtask : t_retry
  task automatic t_read();
    wr(`ADR_CTRL, 32'h10);
    for (int i = 0; i < 5; i++) begin
      @(posedge clk);
      rd_data <= {32'h0123_4567 + 32'(i), 32'h89ab_cdef + 32'(i)};
      tgt <= mk(1'b1, 8'h08, i < 4 ? 7'h40 >> i : 7'h00);
      pci_far_model_inst.txn(`CMD_MEM_RD, 32'h0, 1'b0, dec, late);
      check(trm(dec), {31'h0, i == 4}, "disconnect");
      check(dec.ad[31:0], 32'h89ab_cdef + 32'(i), "read data");
      check({31'h0, late.par}, {31'h0, ^(32'h89ab_cdef + 32'(i))}, "read parity");
      check({31'h0, late.par64}, {31'h0, ^(32'h0123_4567 + 32'(i))}, "upper read parity");
      check({30'h0, dec.ad_oe, late.par_oe}, 32'h3, "read drive");
    end
    wr(`ADR_CTRL, 32'h0);
    $display("read test done");
  endtask : t_read
  task automatic t_abort();
    int l0;
    for (int j = 0; j < 3; j++) begin
      l0 = n_log;
      @(posedge clk);
      tgt <= mk(1'b1, 8'h08, 7'h04 >> j);
      pci_far_model_inst.txn(`CMD_MEM_RD, 32'h0, 1'b0, dec, late);
      check(trm(dec), 32'h6, "abort pins");
      check(32'(n_log - l0), 32'h1, "abort logged");
      rd_chk(`ADR_STAT, 32'h6, 32'h6, "abort flags");
      wr(`ADR_STAT, 32'hf);
    end
    $display("abort test done");
  endtask : t_abort
  task automatic t_parity();
    int         l0, p0;
    logic [1:0] c;
    // Cases: response on with error, response off with error, response on without error.
    for (int k = 0; k < 3; k++) begin
      c = {k != 1, k != 2};
      wr(`ADR_CTRL, {31'h0, c[1]});
      l0 = n_log;
      p0 = n_perr;
      @(posedge clk);
      tgt <= mk(1'b0, 8'h00, 7'h00);
      pci_far_model_inst.txn(`CMD_MEM_WR, 32'hdead_0000 + 32'(k), c[0], dec, late);
      check({31'h0, n_perr > p0}, {31'h0, &c}, "parity error pin");
      check(32'(n_log - l0), {31'h0, c[0]}, "parity logged");
      rd_chk(`ADR_STAT, 32'h5, {29'h0, c[0], 1'b0, c[0]}, "parity flags");
      wr(`ADR_STAT, 32'hf);
    end
    wr(`ADR_CTRL, 32'h0);
    $display("parity test done");
  endtask : t_parity
  task automatic t_master();
    logic [3:0] legal [9] = '{4'h0, 4'h2, 4'h3, 4'h6, 4'h7, 4'ha, 4'hb, 4'hc, 4'he};
    logic [3:0] bad [3] = '{`CMD_SPECIAL, `CMD_DUAL, `CMD_MWI};
    int         d0, f0;
    f0 = n_frame;
    pulse(`CMD_MEM_RDL);
    repeat (8 * 6) @(posedge clk);
    check(32'(n_frame - f0), 32'h0, "no start without enable");
    d0 = n_done;
    wr(`ADR_CTRL, 32'h2);
    wait_done(d0);
    check({28'h0, last_cmd}, {28'h0, `CMD_MEM_RDL}, "held command");
    foreach (legal[m]) begin
      d0 = n_done;
      if (m % 2 == 1) wr(`ADR_MCMD, {28'h0, legal[m]});
      else pulse(legal[m]);
      wait_done(d0);
      check({28'h0, last_cmd}, {28'h0, legal[m]}, "issued command");
    end
    f0 = n_frame;
    foreach (bad[m]) begin
      wr(`ADR_STAT, 32'hf);
      pulse(bad[m]);
      repeat (8 * 6) @(posedge clk);
      rd_chk(`ADR_STAT, 32'h8, 32'h8, "command refused");
    end
    check(32'(n_frame - f0), 32'h0, "no refused start");
    check(32'(n_bad), 32'h0, "grant and role order");
    $display("master test done");
  endtask : t_master
  task automatic t_arb();
    int d0;
    ext_arb = 1'b0;
    wr(`ADR_CTRL, 32'ha);
    repeat (8 * 4) @(posedge clk);
    check({31'h0, pci_out.arb_gnt_n}, 32'h1, "parked on own master");
    pci_far_model_inst.pci_in.other_req_n <= 1'b0;
    repeat (8 * 4) @(posedge clk);
    check({31'h0, pci_out.arb_gnt_n}, 32'h0, "grant to other agent");
    pci_far_model_inst.pci_in.other_req_n <= 1'b1;
    repeat (8 * 4) @(posedge clk);
    d0 = n_done;
    pulse(`CMD_MEM_WR);
    wait_done(d0);
    check(32'(n_pin), 32'h0, "request kept internal");
    $display("arbiter test done");
  endtask : t_arb

  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    $display("MISMATCH at %0t: watchdog expired", $time);
    summarize();
  end
  initial begin
    rst = 1'b1;
    wb_cyc = 1'b0;
    wb_stb = 1'b0;
    wb_we = 1'b0;
    wb_adr = 4'h0;
    wb_sel = 4'h0;
    wb_dat_i = 32'h0;
    tgt = '0;
    rd_data = 64'h0;
    src_req = 1'b0;
    src_cmd = 4'h0;
    ext_arb = 1'b1;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_retry();
    t_read();
    t_abort();
    t_parity();
    t_master();
    t_arb();
    summarize();
  end
endmodule : pci_target_term_and_master_request_bench
